// [core/enc_state_map.svh]
// Constants for the multi-turn encoder state core.
// Assumes a 100 MHz reference clock; included by core files only.
`ifndef ENC_STATE_MAP_SVH
`define ENC_STATE_MAP_SVH

`define ANGLE_MAX        17'h1FFFF
`define TURN_RESET       16'h0000
`define ANGLE_RESET      17'h00000
`define CLK_FREQ_HZ      100000000
`define TX_START_MS      500
`define TX_START_CYCLES  ((`CLK_FREQ_HZ / 1000) * `TX_START_MS)

`endif

// [core/enc_state_pkg.sv]
// Types for the multi-turn encoder state core.
// Assumes nothing of its surroundings.
package enc_state_pkg;
  typedef enum logic [1:0] {
    OP_NONOP  = 2'b00,
    OP_BACKUP = 2'b01,
    OP_NORMAL = 2'b10
  } op_state_e;
endpackage : enc_state_pkg

// [core/sync2.sv]
// Two-stage level synchroniser.
// Assumes the input is asynchronous to i_ref_clk.
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      meta_r <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : sync2
`default_nettype wire

// [core/startup_timer.sv]
// Power-up delay counter that raises done after a set count.
// Assumes i_start is a synchronous level; dropping it restarts the count.
`timescale 1ns/1ps
`default_nettype none
module startup_timer #(
  parameter int unsigned COUNT = 50000000
) (
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  input  wire logic i_start,
  output logic      o_done
);
  logic [31:0] cnt_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || !i_start) begin
      cnt_r  <= 32'h00000000;
      o_done <= 1'b0;
    end else if (cnt_r >= COUNT - 32'd1) begin
      o_done <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h00000001;
    end
  end
endmodule : startup_timer
`default_nettype wire

// [core/multiturn_encoder_state_core.sv]
// Supply state, position keeping, busy and battery alarm for the encoder.
// Assumes sensor strobes are pin-level and asynchronous; the serial block
// consumes transmit enable, busy and alarm.
`timescale 1ns/1ps
`default_nettype none
`include "enc_state_map.svh"
module multiturn_encoder_state_core
  import enc_state_pkg::*;
#(
  parameter int unsigned TX_START_CYCLES = `TX_START_CYCLES
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  // Supply comparators
  input  wire logic        i_main_ok,
  input  wire logic        i_batt_ok,
  // Sensors
  input  wire logic        i_turn_pulse,
  input  wire logic        i_turn_dir_ccw,
  input  wire logic [16:0] i_angle_sample,
  input  wire logic        i_abs_scan_valid,
  // Alarm clear from link block
  input  wire logic        i_alarm_clear,
  // Outputs
  output logic [16:0]      o_single_turn_angle,
  output logic [15:0]      o_turn_counter,
  output logic [1:0]       o_op_state,
  output logic             o_tx_enable,
  output logic             o_busy,
  output logic             o_batt_alarm
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic main_s;
  logic batt_s;
  logic pulse_s;
  logic dir_s;
  logic scan_s;

  sync2 u_sync_main (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_async   (i_main_ok),
    .o_sync    (main_s)
  );

  sync2 u_sync_batt (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_async   (i_batt_ok),
    .o_sync    (batt_s)
  );

  sync2 u_sync_pulse (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_async   (i_turn_pulse),
    .o_sync    (pulse_s)
  );

  sync2 u_sync_dir (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_async   (i_turn_dir_ccw),
    .o_sync    (dir_s)
  );

  sync2 u_sync_scan (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_async   (i_abs_scan_valid),
    .o_sync    (scan_s)
  );

  // ----------------------------------------
  // Angle bus capture
  // ----------------------------------------
  // Angle bus passes two registers every cycle; bits settle well before a valid scan
  logic [16:0] angle_m_r;
  logic [16:0] angle_s_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      angle_m_r <= `ANGLE_RESET;
      angle_s_r <= `ANGLE_RESET;
    end else begin
      angle_m_r <= i_angle_sample;
      angle_s_r <= angle_m_r;
    end
  end

  // ----------------------------------------
  // Operating state
  // ----------------------------------------
  op_state_e state_r;
  op_state_e state_nxt;

  // Main supply wins; battery alone only keeps the turn count alive
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      OP_NORMAL: begin
        if (!main_s && batt_s) begin
          state_nxt = OP_BACKUP;
        end else if (!main_s) begin
          state_nxt = OP_NONOP;
        end
      end
      OP_BACKUP: begin
        if (main_s) begin
          state_nxt = OP_NORMAL;
        end else if (!batt_s) begin
          state_nxt = OP_NONOP;
        end
      end
      OP_NONOP: begin
        if (main_s) begin
          state_nxt = OP_NORMAL;
        end else if (batt_s) begin
          state_nxt = OP_BACKUP;
        end
      end
      default: begin
        state_nxt = OP_NONOP;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_r <= OP_NONOP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Supply state events
  // ----------------------------------------
  // Entry events look one cycle ahead so the flags line up with o_op_state
  logic enter_normal;
  logic enter_nonop;
  logic in_normal;
  assign enter_normal = (state_nxt == OP_NORMAL) && (state_r != OP_NORMAL);
  assign enter_nonop  = (state_nxt == OP_NONOP) && (state_r != OP_NONOP);
  assign in_normal    = (state_r == OP_NORMAL);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_op_state <= OP_NONOP;
    end else begin
      o_op_state <= state_nxt;
    end
  end

  // ----------------------------------------
  // Turn edge detection
  // ----------------------------------------
  // Detector starts low like the idle pin, so reset makes no false edge
  logic pulse_d_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pulse_d_r <= 1'b0;
    end else begin
      pulse_d_r <= pulse_s;
    end
  end

  logic turn_step;
  assign turn_step = pulse_s && !pulse_d_r;

  // Counting stops only when both supplies are gone
  logic count_en;
  assign count_en = turn_step && (state_r != OP_NONOP);

  // ----------------------------------------
  // Turn counter
  // ----------------------------------------
  // Battery-backed value: every i_reset clears it to TURN_RESET
  logic [15:0] turns_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      turns_r <= `TURN_RESET;
    end else if (count_en) begin
      // Direction high counts up; plain 16-bit arithmetic wraps both ways
      if (dir_s) begin
        turns_r <= turns_r + 16'h0001;
      end else begin
        turns_r <= turns_r - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Single-turn angle
  // ----------------------------------------
  // Out-of-range samples cannot occur in 17 bits; clamp guards the limit
  logic [16:0] angle_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      angle_r <= `ANGLE_RESET;
    end else if (in_normal && scan_s) begin
      if (angle_s_r > `ANGLE_MAX) begin
        angle_r <= `ANGLE_MAX;
      end else begin
        angle_r <= angle_s_r;
      end
    end
  end

  // ----------------------------------------
  // Busy flag
  // ----------------------------------------
  // Busy holds until a valid scan in normal; a scan in the entry cycle is ignored and entry sets busy
  logic busy_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      busy_r <= 1'b1;
    end else if (in_normal && scan_s) begin
      busy_r <= 1'b0;
    end else if (enter_normal || !in_normal) begin
      busy_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Transmit start delay
  // ----------------------------------------
  // Timer restarts on every return to normal
  logic tx_ready;
  startup_timer #(.COUNT(TX_START_CYCLES)) u_tx_timer (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_start   (in_normal),
    .o_done    (tx_ready)
  );

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_tx_enable <= 1'b0;
    end else begin
      o_tx_enable <= in_normal && tx_ready;
    end
  end

  // ----------------------------------------
  // Battery alarm
  // ----------------------------------------
  // Latch sets on non-op entry; set wins over a clear in the same cycle
  // Non-op straight out of reset sets nothing: it needs a transition
  logic alarm_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      alarm_r <= 1'b0;
    end else if (enter_nonop) begin
      alarm_r <= 1'b1;
    end else if (i_alarm_clear && in_normal) begin
      alarm_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // One block per output keeps every port a plain flip-flop
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_single_turn_angle <= `ANGLE_RESET;
    end else begin
      o_single_turn_angle <= angle_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_turn_counter <= `TURN_RESET;
    end else begin
      o_turn_counter <= turns_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_busy <= 1'b1;
    end else begin
      o_busy <= busy_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_batt_alarm <= 1'b0;
    end else begin
      o_batt_alarm <= alarm_r;
    end
  end

endmodule : multiturn_encoder_state_core
`default_nettype wire

// [sim/enc_core_props.sv]
// Port checker for the encoder state core.
// Assumes binding onto the core; one clock.
`timescale 1ns/1ps
`default_nettype none
module enc_core_props #(
  parameter int unsigned TX_START_CYCLES = 20
) (
  input wire logic        i_ref_clk,
  input wire logic        i_reset,
  input wire logic        i_abs_scan_valid,
  input wire logic [16:0] o_single_turn_angle,
  input wire logic [15:0] o_turn_counter,
  input wire logic [1:0]  o_op_state,
  input wire logic        o_tx_enable,
  input wire logic        o_busy,
  input wire logic        o_batt_alarm
);
  logic [7:0] norm_r;
  wire        nrm = (o_op_state == 2'h2);
  // Saturates so long normal runs never wrap
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || !nrm) norm_r <= 8'h00;
    else if (norm_r != 8'hFF) norm_r <= norm_r + 8'h01;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  sequence s_scan;
    (nrm && i_abs_scan_valid) [*6];
  endsequence
  sequence s_nonop;
    o_op_state == 2'h0 && $past(o_op_state) != 2'h0;
  endsequence
  a_state_legal: assert property (o_op_state != 2'h3)
    else $error("illegal state code");
  a_tx_normal: assert property (o_tx_enable |-> nrm || $past(nrm))
    else $error("tx outside normal");
  a_tx_early: assert property ($rose(o_tx_enable) |-> norm_r >= TX_START_CYCLES)
    else $error("tx too early");
  a_tx_late: assert property (norm_r < 8'(TX_START_CYCLES + 8) || o_tx_enable)
    else $error("tx too late");
  a_busy_idle: assert property (!nrm [*3] |-> o_busy)
    else $error("busy low outside normal");
  a_busy_fall: assert property ($fell(o_busy) |-> nrm)
    else $error("busy fell outside normal");
  a_scan_clear: assert property (s_scan |-> !o_busy)
    else $error("busy kept after scan");
  a_alarm_entry: assert property (s_nonop |-> ##[0:2] o_batt_alarm)
    else $error("alarm not latched");
  a_alarm_cause: assert property ($rose(o_batt_alarm) |-> !o_op_state || !$past(o_op_state))
    else $error("alarm without nonop");
  a_angle_norm: assert property ($changed(o_single_turn_angle) |-> $past(nrm) || $past(nrm, 2))
    else $error("angle moved outside normal");
  a_turn_step: assert property ($changed(o_turn_counter) |->
    o_turn_counter == 16'($past(o_turn_counter) + 16'h1) ||
    o_turn_counter == 16'($past(o_turn_counter) - 16'h1))
    else $error("turn count jumped");
endmodule : enc_core_props
bind multiturn_encoder_state_core enc_core_props #(.TX_START_CYCLES(TX_START_CYCLES)) props_inst (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_abs_scan_valid(i_abs_scan_valid),
  .o_single_turn_angle(o_single_turn_angle), .o_turn_counter(o_turn_counter),
  .o_op_state(o_op_state), .o_tx_enable(o_tx_enable), .o_busy(o_busy),
  .o_batt_alarm(o_batt_alarm));
`default_nettype wire

// [sim/link_host_model.sv]
// Servo host on the link side of the core.
// Assumes the bench raises i_clear_req to ask for an alarm clear.
`timescale 1ns/1ps
`default_nettype none
module link_host_model (
  input  wire logic i_ref_clk,
  input  wire logic i_tx_enable,
  input  wire logic i_batt_alarm,
  input  wire logic i_clear_req,
  output logic      o_alarm_clear
);
  // Host acts on the alarm only once the link is up
  always @(posedge i_ref_clk) o_alarm_clear <= i_clear_req && i_tx_enable && i_batt_alarm;
endmodule : link_host_model
`default_nettype wire

// [sim/multiturn_encoder_state_core_tb.sv]
// Self-checking bench for the encoder state core.
// Assumes the host model answers alarm clear requests.
`timescale 1ns/1ps
`default_nettype none
module multiturn_encoder_state_core_tb;
  localparam int unsigned TXC = 20;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        m_ok = 1'b0;
  logic        b_ok = 1'b1;
  logic        pls = 1'b0;
  logic        ccw = 1'b1;
  logic [16:0] ang = 17'h00000;
  logic        scan = 1'b0;
  logic        req = 1'b0;
  logic        clr;
  logic [16:0] ang_q;
  logic [15:0] trn_q;
  logic [1:0]  st_q;
  logic        tx_q;
  logic        bsy_q;
  logic        alm_q;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  multiturn_encoder_state_core #(.TX_START_CYCLES(TXC)) multiturn_encoder_state_core_inst (
    .i_ref_clk(clk), .i_reset(rst), .i_main_ok(m_ok), .i_batt_ok(b_ok),
    .i_turn_pulse(pls), .i_turn_dir_ccw(ccw), .i_angle_sample(ang),
    .i_abs_scan_valid(scan), .i_alarm_clear(clr), .o_single_turn_angle(ang_q),
    .o_turn_counter(trn_q), .o_op_state(st_q), .o_tx_enable(tx_q), .o_busy(bsy_q),
    .o_batt_alarm(alm_q));
  link_host_model link_host_model_inst (.i_ref_clk(clk), .i_tx_enable(tx_q),
    .i_batt_alarm(alm_q), .i_clear_req(req), .o_alarm_clear(clr));
  initial forever #5 clk = ~clk;
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors = num_errors + 1;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cy
  task automatic sup(input logic m, input logic b);
    @(posedge clk);
    m_ok <= m;
    b_ok <= b;
    cy(4);
  endtask : sup
  // Pulses held three cycles each way to clear the synchroniser
  task automatic turn(input logic dir, input int n);
    repeat (n) begin
      @(posedge clk);
      ccw <= dir;
      pls <= 1'b1;
      repeat (3) @(posedge clk);
      pls <= 1'b0;
      repeat (2) @(posedge clk);
    end
    cy(1);
  endtask : turn
  task automatic wait_tx();
    int k;
    k = 0;
    while (tx_q !== 1'b1 && k < TXC + 10) begin
      cy(1);
      k++;
    end
    chk("tx_enable", tx_q, 1'b1);
    chk("tx_delay", k >= TXC - 4, 1'b1);
  endtask : wait_tx
  task automatic t_reset();
    chk("angle", ang_q, 17'h00000);
    chk("turns", trn_q, 16'h0000);
    chk("state", st_q, 2'h0);
    chk("busy", bsy_q, 1'b1);
    chk("alarm", alm_q, 1'b0);
    chk("tx_reset", tx_q, 1'b0);
  endtask : t_reset
  task automatic t_normal();
    sup(1'b1, 1'b1);
    chk("state", st_q, 2'h2);
    chk("tx_early", tx_q, 1'b0);
    chk("busy", bsy_q, 1'b1);
    wait_tx();
    @(posedge clk);
    ang <= 17'h1FFFF;
    scan <= 1'b1;
    cy(6);
    chk("angle_max", ang_q, 17'h1FFFF);
    chk("busy_clear", bsy_q, 1'b0);
    @(posedge clk);
    ang <= 17'h00000;
    cy(6);
    chk("angle_zero", ang_q, 17'h00000);
    @(posedge clk);
    scan <= 1'b0;
  endtask : t_normal
  task automatic t_turns();
    turn(1'b1, 3);
    chk("turns_up", trn_q, 16'h0003);
    turn(1'b0, 4);
    chk("turns_wrap", trn_q, 16'hFFFF);
    turn(1'b1, 3);
    chk("turns_back", trn_q, 16'h0002);
  endtask : t_turns
  task automatic t_backup();
    sup(1'b0, 1'b1);
    chk("state", st_q, 2'h1);
    chk("tx_off", tx_q, 1'b0);
    turn(1'b1, 2);
    chk("turns_bk", trn_q, 16'h0004);
    sup(1'b1, 1'b1);
    chk("turns_kept", trn_q, 16'h0004);
    chk("busy_entry", bsy_q, 1'b1);
  endtask : t_backup
  task automatic t_nonop();
    sup(1'b0, 1'b0);
    chk("state", st_q, 2'h0);
    chk("alarm_set", alm_q, 1'b1);
    turn(1'b1, 1);
    chk("turns_halt", trn_q, 16'h0004);
    sup(1'b1, 1'b1);
    chk("alarm_held", alm_q, 1'b1);
    wait_tx();
    @(posedge clk);
    req <= 1'b1;
    cy(4);
    chk("alarm_clear", alm_q, 1'b0);
    @(posedge clk);
    req <= 1'b0;
  endtask : t_nonop
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cy(1);
    t_reset();
    t_normal();
    t_turns();
    t_backup();
    t_nonop();
    wrap_up();
  end
endmodule : multiturn_encoder_state_core_tb
`default_nettype wire
